// *** fspc_defines.svh ***
// Register map, field positions, reset values and keys of the flash control
`ifndef FSPC_DEFINES_SVH
`define FSPC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices and APB byte addresses (index times four)
// ----------------------------------------------------------------------
`define FSPC_IDX_ADDR      14'h081a
`define FSPC_IDX_DATA      14'h081c
`define FSPC_IDX_CTRL      14'h081e
`define FSPC_IDX_KEY       14'h081f
`define FSPC_BA_ADDR       {`FSPC_IDX_ADDR, 2'b00}
`define FSPC_BA_DATA       {`FSPC_IDX_DATA, 2'b00}
`define FSPC_BA_CTRL       {`FSPC_IDX_CTRL, 2'b00}
`define FSPC_BA_KEY        {`FSPC_IDX_KEY, 2'b00}

// ----------------------------------------------------------------------
// Field widths and control bit positions
// ----------------------------------------------------------------------
`define FSPC_ADDR_W        15
`define FSPC_DATA_W        14
`define FSPC_KEY_W         8
`define FSPC_ROW_WORDS     32
`define FSPC_BIT_RD        0
`define FSPC_BIT_WR        1
`define FSPC_BIT_EN        2
`define FSPC_BIT_FAULT     3
`define FSPC_BIT_ERASE     4
`define FSPC_BIT_LATCH     5
`define FSPC_BIT_REGION    6

// ----------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------
`define FSPC_ADDR_RST      15'h0000
`define FSPC_KEY_RST       8'h00
`define FSPC_KEY_FIRST     8'h55
`define FSPC_KEY_SECOND    8'haa
`define FSPC_LATCH_ERASED  14'h3fff

`endif

// *** fspc_pkg.sv ***
// Types shared by the flash self-program control block
package fspc_pkg;

    typedef enum logic [1:0] {
        FSPC_OP_NONE,
        FSPC_OP_ERASE,
        FSPC_OP_PROGRAM
    } fspc_op_t;

    typedef enum logic [1:0] {
        FSPC_ST_IDLE,
        FSPC_ST_LOAD,
        FSPC_ST_FLASH
    } fspc_state_t;

    typedef enum logic [1:0] {
        FSPC_UL_LOCKED,
        FSPC_UL_HALF,
        FSPC_UL_ARMED
    } fspc_unlock_t;

    // Control register image, bit 6 down to bit 0
    typedef struct packed {
        logic region;
        logic latch_only;
        logic erase;
        logic fault;
        logic enable;
        logic start;
        logic rd;
    } fspc_ctrl_t;

endpackage

// *** fspc_unlock.sv ***
// Two-value unlock sequence tracker for the flash control block
`timescale 1ns/1ns
`default_nettype none
`include "fspc_defines.svh"

module fspc_unlock (
    input  wire logic                   clk,         // Core clock
    input  wire logic                   nrst,        // Async reset, low
    input  wire logic                   key_write,   // Unlock key written
    input  wire logic [`FSPC_KEY_W-1:0] key_value,   // Value written
    input  wire logic                   other_write, // Any other write
    input  wire logic                   start_try,   // Start bit written 1
    output logic                        armed,       // Start may be taken
    output logic                        broken       // Sequence cut, pulse
);

    fspc_pkg::fspc_unlock_t state;
    fspc_pkg::fspc_unlock_t next_state;
    logic                   next_broken;

    always_comb begin
        next_state  = state;
        next_broken = 1'b0;
        if (key_write) begin
            if (key_value == `FSPC_KEY_FIRST) begin
                next_broken = (state != fspc_pkg::FSPC_UL_LOCKED);
                next_state  = fspc_pkg::FSPC_UL_HALF;
            end else if (state == fspc_pkg::FSPC_UL_HALF &&
                         key_value == `FSPC_KEY_SECOND) begin
                next_state = fspc_pkg::FSPC_UL_ARMED;
            end else begin
                next_broken = (state != fspc_pkg::FSPC_UL_LOCKED);
                next_state  = fspc_pkg::FSPC_UL_LOCKED;
            end
        end else if (start_try) begin
            // The arming is spent by one start attempt
            next_broken = (state == fspc_pkg::FSPC_UL_HALF);
            next_state  = fspc_pkg::FSPC_UL_LOCKED;
        end else if (other_write) begin
            next_broken = (state != fspc_pkg::FSPC_UL_LOCKED);
            next_state  = fspc_pkg::FSPC_UL_LOCKED;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state  <= fspc_pkg::FSPC_UL_LOCKED;
            broken <= 1'b0;
        end else begin
            state  <= next_state;
            broken <= next_broken;
        end
    end

    assign armed = (state == fspc_pkg::FSPC_UL_ARMED);

endmodule // fspc_unlock

`default_nettype wire

// *** fspc_latch_row.sv ***
// Row of write latches that collects one flash row before programming
`timescale 1ns/1ns
`default_nettype none
`include "fspc_defines.svh"

module fspc_latch_row #(
    parameter int WORDS = `FSPC_ROW_WORDS,
    parameter int W     = `FSPC_DATA_W
) (
    input  wire logic                     clk,       // Core clock
    input  wire logic                     nrst,      // Async reset, low
    input  wire logic                     load,      // Load one latch
    input  wire logic [$clog2(WORDS)-1:0] index,     // Latch selected
    input  wire logic [W-1:0]             din,       // Word to load
    input  wire logic                     clear_all, // Back to erased value
    output logic      [WORDS*W-1:0]       row        // Whole row to flash
);

    logic [W-1:0] word [WORDS];
    logic [W-1:0] next_word [WORDS];

    always_comb begin
        for (int i = 0; i < WORDS; i++) begin
            next_word[i] = word[i];
            if (clear_all) begin
                next_word[i] = `FSPC_LATCH_ERASED;
            end else if (load && index == i[$clog2(WORDS)-1:0]) begin
                next_word[i] = din;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < WORDS; i++) begin
                word[i] <= `FSPC_LATCH_ERASED;
            end
        end else begin
            for (int i = 0; i < WORDS; i++) begin
                word[i] <= next_word[i];
            end
        end
    end

    always_comb begin
        for (int i = 0; i < WORDS; i++) begin
            row[i*W +: W] = word[i];
        end
    end

endmodule // fspc_latch_row

`default_nettype wire

// *** fspc_ctrl.sv ***
// Flash self-program control block: APB registers, unlock, op sequencing
//
// Notes on behaviour
// - 15-bit address register, resets to zero
// - Address bit 15 reads zero, never defined
// - Data register kept across warm resets
// - Region bit picks info area or main flash
// - Latch-only loads latch; ignored when erasing
// - Erase bit erases whole 32-word row
// - Fault on warm reset during a flash op, broken unlock, protection
// - Fault cleared by software or by reset; settable
// - Program enable low blocks program and erase
// - Start accepted only after 0x55 then 0xAA
// - Start self-clears when operation completes
// - Writing zero to busy start ignored
// - Read start fetches word, then self-clears
// - Fault readback unreliable while busy
// - Unlock key: 8-bit write-only, resets zero
// - Protected erase: start cleared, fault set
// - Latch load ignores protection, no flash access
// - Program writes row, latches reset to 0x3FFF
// - Invalid info-region read returns zeros
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "fspc_defines.svh"

module fspc_ctrl (
    input  wire logic                     clk,          // Core clock
    input  wire logic                     nrst,         // Async reset, low
    input  wire logic                     cold_start,   // Power-on reset seen
    input  wire logic                     psel,         // APB select
    input  wire logic                     penable,      // APB enable
    input  wire logic                     pwrite,       // APB direction
    input  wire logic [15:0]              paddr,        // APB byte address
    input  wire logic [31:0]              pwdata,       // APB write data
    output logic      [31:0]              prdata,       // APB read data
    output logic                          pready,       // APB ready
    output logic                          pslverr,      // APB error
    output logic      [`FSPC_ADDR_W-1:0]  flash_addr,   // Flash word address
    output logic                          flash_region, // Info region select
    output logic                          flash_start,  // Op start pulse
    output fspc_pkg::fspc_op_t            flash_op,     // Op kind
    output logic [`FSPC_ROW_WORDS*`FSPC_DATA_W-1:0] flash_row, // Latched row
    input  wire logic                     flash_done,   // Self-timed op over
    input  wire logic                     flash_wp,     // Address protected
    input  wire logic [`FSPC_DATA_W-1:0]  flash_rdata,  // Read word
    input  wire logic                     flash_rd_ok   // Read address valid
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [`FSPC_ADDR_W-1:0]  addr;
    logic [`FSPC_ADDR_W-1:0]  next_addr;
    logic [`FSPC_DATA_W-1:0]  data;
    logic [`FSPC_DATA_W-1:0]  next_data;
    fspc_pkg::fspc_ctrl_t     ctrl;
    fspc_pkg::fspc_ctrl_t     next_ctrl;
    fspc_pkg::fspc_state_t    state;
    fspc_pkg::fspc_state_t    next_state;
    fspc_pkg::fspc_op_t       next_flash_op;
    logic                     next_flash_start;
    logic [31:0]              next_prdata;
    logic                     next_pslverr;
    logic                     running;
    logic                     op_live;
    logic                     next_op_live;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    logic hit_addr;
    logic hit_data;
    logic hit_ctrl;
    logic hit_key;
    logic mapped;
    logic setup;
    logic wr_acc;
    logic wr_addr;
    logic wr_data;
    logic wr_ctrl;
    logic wr_key;
    logic busy;

    assign hit_addr = (paddr == `FSPC_BA_ADDR);
    assign hit_data = (paddr == `FSPC_BA_DATA);
    assign hit_ctrl = (paddr == `FSPC_BA_CTRL);
    assign hit_key  = (paddr == `FSPC_BA_KEY);
    assign mapped   = hit_addr | hit_data | hit_ctrl | hit_key;
    assign setup    = psel & ~penable;
    assign wr_acc   = psel & penable & pwrite & mapped;
    assign wr_addr  = wr_acc & hit_addr;
    assign wr_data  = wr_acc & hit_data;
    assign wr_ctrl  = wr_acc & hit_ctrl;
    assign wr_key   = wr_acc & hit_key;
    assign busy     = (state != fspc_pkg::FSPC_ST_IDLE);

    // Zero wait states; read data was captured in the setup cycle
    assign pready = psel & penable;

    // ------------------------------------------------------------------
    // Unlock sequence and write latches
    // ------------------------------------------------------------------
    logic start_try;
    logic armed;
    logic unlock_broken;
    logic latch_load;
    logic latch_clear;

    assign start_try = wr_ctrl & pwdata[`FSPC_BIT_WR];

    // Key value is consumed here only; nothing stores it for readback
    fspc_unlock u_unlock (
        .clk         (clk),
        .nrst        (nrst),
        .key_write   (wr_key),
        .key_value   (pwdata[`FSPC_KEY_W-1:0]),
        .other_write (wr_acc & ~wr_key & ~start_try),
        .start_try   (start_try),
        .armed       (armed),
        .broken      (unlock_broken)
    );

    fspc_latch_row #(
        .WORDS (`FSPC_ROW_WORDS),
        .W     (`FSPC_DATA_W)
    ) u_latch (
        .clk       (clk),
        .nrst      (nrst),
        .load      (latch_load),
        .index     (addr[$clog2(`FSPC_ROW_WORDS)-1:0]),
        .din       (data),
        .clear_all (latch_clear),
        .row       (flash_row)
    );

    // ------------------------------------------------------------------
    // Operation sequencing
    // ------------------------------------------------------------------
    logic reset_fault;
    logic wp_fault;

    // A flash op still live at the last reset leaves a fault behind
    assign reset_fault = ~running & op_live & ~cold_start;

    always_comb begin
        next_state       = state;
        next_ctrl        = ctrl;
        next_addr        = addr;
        next_data        = data;
        next_flash_op    = flash_op;
        next_flash_start = 1'b0;
        latch_load       = 1'b0;
        latch_clear      = 1'b0;
        wp_fault         = 1'b0;

        // Config is frozen while an op runs to keep its target stable
        if (wr_addr && !busy) begin
            next_addr = pwdata[`FSPC_ADDR_W-1:0];
        end
        if (wr_data && !busy) begin
            next_data = pwdata[`FSPC_DATA_W-1:0];
        end
        if (wr_ctrl) begin
            next_ctrl.fault = pwdata[`FSPC_BIT_FAULT];
            next_ctrl.enable = pwdata[`FSPC_BIT_EN];
            if (!busy) begin
                next_ctrl.region     = pwdata[`FSPC_BIT_REGION];
                next_ctrl.latch_only = pwdata[`FSPC_BIT_LATCH];
                if (pwdata[`FSPC_BIT_ERASE]) begin
                    next_ctrl.erase = 1'b1;
                end
                if (pwdata[`FSPC_BIT_RD]) begin
                    next_ctrl.rd = 1'b1;
                end
            end
        end

        // Read completes in the cycle after it is requested
        if (ctrl.rd) begin
            next_ctrl.rd = 1'b0;
            next_data = flash_rd_ok ? flash_rdata : '0;
        end

        unique case (state)
            fspc_pkg::FSPC_ST_IDLE: begin
                if (start_try && armed && ctrl.enable) begin
                    if (ctrl.erase) begin
                        if (flash_wp) begin
                            wp_fault = 1'b1;
                        end else begin
                            next_ctrl.start  = 1'b1;
                            next_flash_op    = fspc_pkg::FSPC_OP_ERASE;
                            next_flash_start = 1'b1;
                            next_state       = fspc_pkg::FSPC_ST_FLASH;
                        end
                    end else if (ctrl.latch_only) begin
                        next_ctrl.start = 1'b1;
                        latch_load      = 1'b1;
                        next_state      = fspc_pkg::FSPC_ST_LOAD;
                    end else if (flash_wp) begin
                        wp_fault = 1'b1;
                    end else begin
                        next_ctrl.start  = 1'b1;
                        next_flash_op    = fspc_pkg::FSPC_OP_PROGRAM;
                        next_flash_start = 1'b1;
                        next_state       = fspc_pkg::FSPC_ST_FLASH;
                    end
                end
            end
            fspc_pkg::FSPC_ST_LOAD: begin
                next_ctrl.start = 1'b0;
                next_state      = fspc_pkg::FSPC_ST_IDLE;
            end
            fspc_pkg::FSPC_ST_FLASH: begin
                // Software cannot drop start here; only completion does
                next_ctrl.start = 1'b1;
                if (flash_done) begin
                    next_ctrl.start = 1'b0;
                    next_ctrl.erase = 1'b0;
                    latch_clear = (flash_op == fspc_pkg::FSPC_OP_PROGRAM);
                    next_flash_op = fspc_pkg::FSPC_OP_NONE;
                    next_state    = fspc_pkg::FSPC_ST_IDLE;
                end
            end
        endcase

        // Hardware sets win over a software clear in the same cycle
        if (wp_fault || unlock_broken || reset_fault) begin
            next_ctrl.fault = 1'b1;
        end
    end

    // Tracks a live flash op through resets; cleared by cold_start, else updated only while running
    always_comb begin
        next_op_live = op_live;
        if (cold_start) begin
            next_op_live = 1'b0;
        end else if (running) begin
            next_op_live = (state == fspc_pkg::FSPC_ST_FLASH);
        end
    end

    // ------------------------------------------------------------------
    // APB read capture
    // ------------------------------------------------------------------
    always_comb begin
        next_prdata  = prdata;
        next_pslverr = pslverr;
        if (setup) begin
            next_pslverr = ~mapped;
            next_prdata  = '0;
            if (!pwrite) begin
                if (hit_addr) begin
                    next_prdata[`FSPC_ADDR_W-1:0] = addr;
                end else if (hit_data) begin
                    next_prdata[`FSPC_DATA_W-1:0] = data;
                end else if (hit_ctrl) begin
                    next_prdata[6:0] = ctrl;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            addr        <= `FSPC_ADDR_RST;
            ctrl        <= '0;
            state       <= fspc_pkg::FSPC_ST_IDLE;
            flash_op    <= fspc_pkg::FSPC_OP_NONE;
            flash_start <= 1'b0;
            prdata      <= '0;
            pslverr     <= 1'b0;
            running     <= 1'b0;
        end else begin
            addr        <= next_addr;
            ctrl        <= next_ctrl;
            state       <= next_state;
            flash_op    <= next_flash_op;
            flash_start <= next_flash_start;
            prdata      <= next_prdata;
            pslverr     <= next_pslverr;
            running     <= 1'b1;
        end
    end

    // No reset: data survives warm resets, undefined after power-on
    always_ff @(posedge clk) begin
        data    <= next_data;
        op_live <= next_op_live;
    end

    assign flash_addr   = addr;
    assign flash_region = ctrl.region;

endmodule // fspc_ctrl

`default_nettype wire

// *** fspc_ctrl_sva.sv ***
// Port assertions for the flash control block
`timescale 1ns/1ns
`default_nettype none
`include "fspc_defines.svh"

module fspc_ctrl_sva (
    input wire logic               clk,          // Core clock
    input wire logic               nrst,         // Async reset, low
    input wire logic               psel,         // APB select
    input wire logic               penable,      // APB enable
    input wire logic               pwrite,       // APB direction
    input wire logic [15:0]        paddr,        // APB byte address
    input wire logic [31:0]        pwdata,       // APB write data
    input wire logic [14:0]        flash_addr,   // Word address
    input wire logic               flash_region, // Region select
    input wire logic               flash_start,  // Op start pulse
    input wire fspc_pkg::fspc_op_t flash_op,     // Op kind
    input wire logic [447:0]       flash_row,    // Latched row
    input wire logic               flash_done    // Op over
);
    // ----
    // Helpers
    // ----
    logic busy, wr_ok, prog_end;
    assign busy     = flash_op != fspc_pkg::FSPC_OP_NONE;
    assign wr_ok    = psel && penable && pwrite && !busy;
    assign prog_end = flash_op == fspc_pkg::FSPC_OP_PROGRAM && flash_done;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // ----
    // Checks
    // ----
    a_addr_taken: assert property (wr_ok && paddr == `FSPC_BA_ADDR
        |=> flash_addr == $past(pwdata[14:0])) else $error("addr lost");
    a_addr_frozen: assert property (busy && !flash_done
        |=> $stable(flash_addr)) else $error("addr moved");
    a_region_taken: assert property (wr_ok && paddr == `FSPC_BA_CTRL
        |=> flash_region == $past(pwdata[6])) else $error("region lost");
    a_start_pulse: assert property (flash_start
        |=> !flash_start) else $error("long start");
    a_start_op: assert property (flash_start
        |-> busy) else $error("start without op");
    a_op_held: assert property (busy && !flash_done
        |=> flash_op == $past(flash_op)) else $error("op changed");
    a_done_idle: assert property (busy && flash_done
        |=> !busy) else $error("op not ended");
    a_row_erased: assert property (prog_end
        |=> flash_row == {32{14'h3fff}}) else $error("latches not reset");
    a_key_no_start: assert property (psel && penable && pwrite
        && paddr == `FSPC_BA_KEY |=> !flash_start [*2])
        else $error("early start");

    c_program: cover property (prog_end);
    c_erase: cover property (flash_op == fspc_pkg::FSPC_OP_ERASE && flash_done);
    c_region: cover property (wr_ok && paddr == `FSPC_BA_CTRL && pwdata[6]);
endmodule // fspc_ctrl_sva
`default_nettype wire

// *** fspc_flash_model.sv ***
// Behavioural flash array on the control block's far side
`timescale 1ns/1ns
`default_nettype none

module fspc_flash_model #(
    parameter logic [14:0] WP_BASE = 15'h7000 // Protected from here up
) (
    input  wire logic               clk,          // Core clock
    input  wire logic               nrst,         // Async reset, low
    input  wire logic               slow,         // Long self-timed ops
    input  wire logic [14:0]        flash_addr,   // Word address
    input  wire logic               flash_region, // Region select
    input  wire logic               flash_start,  // Op start pulse
    input  wire fspc_pkg::fspc_op_t flash_op,     // Op kind
    input  wire logic [447:0]       flash_row,    // Latched row
    output logic                    flash_done,   // Op over pulse
    output logic                    flash_wp,     // Address protected
    output logic      [13:0]        flash_rdata,  // Read word
    output logic                    flash_rd_ok   // Read address valid
);
    logic [13:0] mem [0:2047];
    logic [5:0]  cnt;
    logic [10:0] key;
    assign key         = {flash_region, flash_addr[9:0]};
    assign flash_wp    = flash_addr >= WP_BASE;
    assign flash_rd_ok = !flash_region || flash_addr < 15'h0004 ||
        (flash_addr > 15'h0004 && flash_addr < 15'h000c) ||
        (flash_addr >= 15'h0100 && flash_addr < 15'h0300);
    // Invalid places show a pattern, not the last word read
    assign flash_rdata = flash_rd_ok ? mem[key] : 14'h1555;

    initial begin
        foreach (mem[i]) mem[i] = 14'h3fff;
        mem[11'h400] = 14'h0abc;
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt        <= 6'h00;
            flash_done <= 1'b0;
        end else begin
            flash_done <= 1'b0;
            if (flash_start) begin
                cnt <= slow ? 6'd30 : 6'd2;
            end else if (cnt == 6'd1) begin
                cnt        <= 6'h00;
                flash_done <= 1'b1;
                for (int i = 0; i < 32; i++) begin
                    mem[{key[10:5], 5'(i)}] <=
                        flash_op == fspc_pkg::FSPC_OP_ERASE ?
                        14'h3fff : flash_row[i*14+:14];
                end
            end else if (cnt != 6'h00) begin
                cnt <= cnt - 6'd1;
            end
        end
    end
endmodule // fspc_flash_model
`default_nettype wire

// *** flash_self_program_control_bench.sv ***
// Self-checking bench for the flash control block
`timescale 1ns/1ns
`default_nettype none
`include "fspc_defines.svh"

module flash_self_program_control_bench;
    logic               clk = 0, nrst = 0, cold_start = 1, slow = 0;
    logic               psel = 0, penable = 0, pwrite = 0, e;
    logic [15:0]        paddr = 0;
    logic [31:0]        pwdata = 0, prdata, q;
    logic               pready, pslverr, flash_region, flash_start;
    logic [14:0]        flash_addr;
    fspc_pkg::fspc_op_t flash_op;
    logic [447:0]       flash_row;
    logic               flash_done, flash_wp, flash_rd_ok;
    logic [13:0]        flash_rdata;
    int                 errors = 0, samples_checked = 0, cycles, starts;

    fspc_ctrl uut (.clk, .nrst, .cold_start, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .flash_addr,
        .flash_region, .flash_start, .flash_op, .flash_row, .flash_done,
        .flash_wp, .flash_rdata, .flash_rd_ok);
    fspc_flash_model flash (.clk, .nrst, .slow, .flash_addr, .flash_region,
        .flash_start, .flash_op, .flash_row, .flash_done, .flash_wp,
        .flash_rdata, .flash_rd_ok);

    always #5 clk = ~clk;
    always @(posedge clk) begin
        starts += (flash_start === 1'b1);
        cycles++;
        if (cycles == 20000) begin
            errors++;
            print_verdict;
        end
    end

    // ----
    // Bus tasks
    // ----
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        samples_checked++;
        if (s !== x) begin
            errors++;
            $display("wrong value at %0t: %h, want %h", $time, s, x);
        end
    endtask
    task automatic rc(input logic [15:0] a, input logic [31:0] m, x);
        apb(1'b0, a, 32'h0);
        chk(q & m, x);
    endtask
    task automatic wc(input logic [7:0] c);
        wr(`FSPC_BA_CTRL, {24'h0, c});
    endtask
    task automatic rk(input logic [7:0] m, x);
        rc(`FSPC_BA_CTRL, {24'h0, m}, {24'h0, x});
    endtask
    task automatic fc(input logic [31:0] a, input logic [7:0] c,
                      input logic [31:0] x);
        wr(`FSPC_BA_ADDR, a);
        wc(c);
        rc(`FSPC_BA_DATA, 32'hffff_ffff, x);
    endtask
    task automatic go(input logic [7:0] c);
        wr(`FSPC_BA_KEY, 32'h0000_0055);
        wr(`FSPC_BA_KEY, 32'h0000_00aa);
        wc(c);
    endtask
    task automatic idle;
        do rk(8'h00, 8'h00); while (q[1] !== 1'b0);
    endtask
    task automatic print_verdict;
        if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ----
    // Tests
    // ----
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        cold_start <= 1'b0;
        rc(`FSPC_BA_ADDR, 32'hffff_ffff, 32'h0);
        rc(`FSPC_BA_CTRL, 32'hffff_ffff, 32'h0);
        rc(`FSPC_BA_KEY, 32'hffff_ffff, 32'h0);
        rc(16'h0010, 32'h0, 32'h0);
        chk({31'h0, e}, 32'h1);
        wr(`FSPC_BA_ADDR, 32'hffff_ffff);
        rc(`FSPC_BA_ADDR, 32'hffff_ffff, 32'h0000_7fff);
        wr(`FSPC_BA_DATA, 32'hffff_ffff);
        rc(`FSPC_BA_DATA, 32'hffff_ffff, 32'h0000_3fff);
        wc(8'h24);
        for (int i = 0; i < 32; i++) begin
            wr(`FSPC_BA_ADDR, 32'h0000_0040 + i);
            wr(`FSPC_BA_DATA, 32'h0000_2000 + i);
            go(8'h26);
            chk({18'h0, flash_row[i*14+:14]}, 32'h0000_2000 + i);
        end
        chk(starts, 0);
        wc(8'h04);
        go(8'h06);
        idle();
        chk({31'h0, flash_row === {32{14'h3fff}}}, 32'h1);
        for (int i = 0; i < 32; i++) fc(32'h40 + i, 8'h05, 32'h2000 + i);
        rk(8'h01, 8'h00);
        wc(8'h14);
        go(8'h16);
        idle();
        rk(8'hff, 8'h04);
        fc(32'h0000_0045, 8'h05, 32'h0000_3fff);
        wc(8'h06);
        rk(8'hff, 8'h04);
        wc(8'h00);
        go(8'h02);
        rk(8'hff, 8'h00);
        chk(starts, 2);
        wr(`FSPC_BA_ADDR, 32'h0000_7040);
        wc(8'h04);
        go(8'h06);
        rk(8'hff, 8'h0c);
        chk(starts, 2);
        wc(8'h04);
        rk(8'hff, 8'h04);
        wc(8'h0c);
        rk(8'hff, 8'h0c);
        wc(8'h04);
        wr(`FSPC_BA_KEY, 32'h0000_0055);
        wr(`FSPC_BA_ADDR, 32'h0000_0060);
        rk(8'hff, 8'h0c);
        wc(8'h04);
        slow <= 1'b1;
        go(8'h06);
        wc(8'h04);
        rk(8'h02, 8'h02);
        idle();
        fc(32'h0000_0004, 8'h45, 32'h0);
        fc(32'h0000_0000, 8'h45, 32'h0000_0abc);
        wr(`FSPC_BA_DATA, 32'h0000_1111);
        go(8'h06);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rk(8'h08, 8'h08);
        rc(`FSPC_BA_DATA, 32'hffff_ffff, 32'h0000_1111);
        print_verdict;
    end
endmodule // flash_self_program_control_bench

bind fspc_ctrl fspc_ctrl_sva chk_sva (.clk, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .flash_addr, .flash_region, .flash_start, .flash_op,
    .flash_row, .flash_done);
`default_nettype wire
